// ### inc/light_prox_pkg.sv
// constants and carrier types for the light/proximity register bank
// assumes one device clock and a byte-wide register port from the serial
// front end, which handles the command byte and address auto-increment
package light_prox_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ANALOG_CONTROL_ADDR = 8'h0f;
  localparam logic [7:0] PART_IDENTITY_ADDR = 8'h12;
  localparam logic [7:0] DEVICE_STATUS_ADDR = 8'h13;
  localparam logic [7:0] LIGHT_CHAN0_LOW_ADDR = 8'h14;
  localparam logic [7:0] LIGHT_CHAN0_HIGH_ADDR = 8'h15;
  localparam logic [7:0] LIGHT_CHAN1_LOW_ADDR = 8'h16;
  localparam logic [7:0] LIGHT_CHAN1_HIGH_ADDR = 8'h17;
  localparam logic [7:0] PROX_RESULT_LOW_ADDR = 8'h18;
  localparam logic [7:0] PROX_RESULT_HIGH_ADDR = 8'h19;
  localparam logic [7:0] PROX_OFFSET_COMP_ADDR = 8'h1e;

  // ****************************************************************
  // reset values and field positions
  // ****************************************************************
  localparam logic [7:0] ANALOG_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PROX_OFFSET_COMP_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  localparam int LED_CURRENT_MSB = 7;
  localparam int LED_CURRENT_LSB = 6;
  localparam int DIODE_SEL_MSB = 5;
  localparam int DIODE_SEL_LSB = 4;
  localparam int PROX_GAIN_MSB = 3;
  localparam int PROX_GAIN_LSB = 2;
  localparam int LIGHT_GAIN_MSB = 1;
  localparam int LIGHT_GAIN_LSB = 0;
  localparam int STAT_PROX_SAT_BIT = 6;
  localparam int STAT_PROX_IRQ_BIT = 5;
  localparam int STAT_LIGHT_IRQ_BIT = 4;
  localparam int STAT_PROX_READY_BIT = 1;
  localparam int STAT_LIGHT_READY_BIT = 0;
  localparam int OFFSET_SIGN_BIT = 7;
  localparam int NUM_RESULTS = 3;
  localparam int RESULT_WIDTH = 16;

  // ****************************************************************
  // led current in tenths of a milliampere, indexed by drive code
  // ****************************************************************
  localparam logic [10:0] LED_CURRENT_FULL [4] =
    '{11'd1200, 11'd600, 11'd300, 11'd150};
  localparam logic [10:0] LED_CURRENT_REDUCED [4] =
    '{11'd150, 11'd75, 11'd38, 11'd19};

  // ****************************************************************
  // gains; light gain in hundredths, reduced column scales codes 0 and 1 by 0.16
  // ****************************************************************
  localparam logic [3:0] PROX_GAIN_TABLE [4] = '{4'd1, 4'd2, 4'd4, 4'd8};
  localparam logic [13:0] LIGHT_GAIN_FULL [4] =
    '{14'd100, 14'd800, 14'd1600, 14'd12000};
  localparam logic [13:0] LIGHT_GAIN_REDUCED [4] =
    '{14'd16, 14'd128, 14'd1600, 14'd12000};

  typedef enum logic [1:0] {
    DIODE_NONE = 2'b00,
    DIODE_FIRST = 2'b01,
    DIODE_SECOND = 2'b10,
    DIODE_RESERVED = 2'b11
  } diode_code_t;

  typedef struct packed {
    logic [1:0] led_current_select;
    diode_code_t prox_photodiode_select;
    logic [1:0] prox_amp_gain;
    logic [1:0] light_amp_gain;
  } analog_ctrl_t;

  typedef struct packed {
    logic prox_saturated_flag;
    logic prox_irq_flag;
    logic light_irq_flag;
    logic prox_result_ready;
    logic light_result_ready;
  } status_in_t;

  // word 0 light channel zero, word 1 light channel one, word 2 proximity
  typedef struct packed {
    logic [NUM_RESULTS-1:0][RESULT_WIDTH-1:0] word;
  } results_t;

endpackage : light_prox_pkg

// ### core/result_shadow.sv
// one 16-bit result with its upper-byte shadow latch
// assumes capture is a one-cycle pulse on the read of the low byte
module result_shadow
  import light_prox_pkg::*;
#(
  parameter int WIDTH = RESULT_WIDTH
) (
  input wire logic sys_clk, // device clock
  input wire logic rst_n, // async reset, active low
  input wire logic capture, // low byte being read
  input wire logic [WIDTH-1:0] live_value, // result from measurement
  output logic [WIDTH/2-1:0] high_shadow // held upper byte
);

  initial begin
    if (WIDTH != 2 * (WIDTH / 2) || WIDTH < 2) begin
      $error("result_shadow: WIDTH must be even and at least 2");
    end
  end

  // ****************************************************************
  // upper byte frozen at the low-byte read
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_shadow <= '0;
    end else if (capture) begin
      high_shadow <= live_value[WIDTH-1:WIDTH/2];
    end
  end

endmodule : result_shadow

// ### core/light_prox_sensor_regs.sv
// register bank of an ambient light and proximity sensor
// assumes a byte-wide register port from the serial front end and a
// measurement engine that supplies results and status levels
//
// Summary of operation
// - drive code gives 120/60/30/15 mA
// - reduce bit gives 15/7.5/3.8/1.9 mA
// - diode select 00 none, 01/10; 11 forbidden
// - control holds drive, diode, two gains
// - read-only fixed part number byte
// - status writes change nothing
// - status bits 7, 3:2 read zero
// - status bit 6 proximity saturation
// - status bit 5 proximity interrupt active
// - status bit 4 light interrupt active
// - status bit 1 proximity result valid
// - status bit 0 light result valid
// - light results at 0x14..0x17 low/high
// - low read latches upper byte shadow
// - shadow survives later conversions
// - proximity result 0x18/0x19, same shadowing
// - offset sign: clear negative, set positive
// - offset register zero after power-up
// - magnitude 6:0 sets shift size
// - reduce bit selects reduced drive column
// - gain-reduce scales 1x, 8x by 0.16
module light_prox_sensor_regs
  import light_prox_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
  parameter int NUM_CHANNELS = NUM_RESULTS
) (
  input wire logic sys_clk, // device clock, 10 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read data, one cycle after strobe
  output logic reg_rvalid, // read data valid pulse
  input wire logic led_current_reduce, // configuration drive reduce
  input wire logic light_gain_reduce, // configuration gain reduce
  input wire status_in_t status_in, // levels from measurement logic
  input wire results_t results_in, // live conversion results
  output logic [10:0] led_current_x10, // led pulse current, 0.1 mA
  output logic first_photodiode_en, // proximity uses first diode
  output logic second_photodiode_en, // proximity uses second diode
  output logic diode_code_bad, // reserved diode code held
  output logic [3:0] prox_gain_factor, // proximity gain 1..8
  output logic [13:0] light_gain_x100, // light gain, hundredths
  output logic prox_offset_positive, // offset shifts data up
  output logic [6:0] prox_offset_magnitude, // offset step count
  output logic [7:0] prox_offset_signed // offset, two's complement
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  initial begin
    if (NUM_CHANNELS != NUM_RESULTS) begin
      $error("light_prox_sensor_regs: NUM_CHANNELS must be 3");
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  analog_ctrl_t analog_control_reg;
  logic [7:0] prox_offset_comp_reg;
  logic [7:0] read_next;
  logic [NUM_CHANNELS-1:0] low_read;
  logic [NUM_CHANNELS-1:0] high_hit;
  logic [NUM_CHANNELS-1:0] low_hit;
  logic [NUM_CHANNELS-1:0][7:0] high_shadow;
  logic [7:0] status_view;
  logic [10:0] led_current_next;
  logic [13:0] light_gain_next;
  logic [7:0] offset_signed_next;

  // ****************************************************************
  // address decode of result pairs
  // ****************************************************************
  generate
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_result
      localparam logic [7:0] LOW_ADDR =
        8'(LIGHT_CHAN0_LOW_ADDR + 8'(2 * ch));
      localparam logic [7:0] HIGH_ADDR = 8'(LOW_ADDR + 8'h01);

      assign low_hit[ch] = (reg_addr == LOW_ADDR);
      assign high_hit[ch] = (reg_addr == HIGH_ADDR);
      // shadow takes the upper byte only on a low-byte read
      assign low_read[ch] = reg_rd && low_hit[ch];

      result_shadow #(
        .WIDTH(RESULT_WIDTH)
      ) u_shadow (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .capture(low_read[ch]),
        .live_value(results_in.word[ch]),
        .high_shadow(high_shadow[ch])
      );
    end
  endgenerate

  // ****************************************************************
  // status view
  // ****************************************************************
  always_comb begin
    status_view = 8'h00;
    status_view[STAT_PROX_SAT_BIT] = status_in.prox_saturated_flag;
    status_view[STAT_PROX_IRQ_BIT] = status_in.prox_irq_flag;
    status_view[STAT_LIGHT_IRQ_BIT] = status_in.light_irq_flag;
    status_view[STAT_PROX_READY_BIT] =
      status_in.prox_result_ready;
    status_view[STAT_LIGHT_READY_BIT] =
      status_in.light_result_ready;
  end

  // ****************************************************************
  // writable registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_control_reg <= analog_ctrl_t'(ANALOG_CONTROL_RESET);
    end else if (reg_wr && reg_addr == ANALOG_CONTROL_ADDR) begin
      analog_control_reg <= analog_ctrl_t'(reg_wdata);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prox_offset_comp_reg <= PROX_OFFSET_COMP_RESET;
    end else if (reg_wr && reg_addr == PROX_OFFSET_COMP_ADDR) begin
      prox_offset_comp_reg <= reg_wdata;
    end
  end

  // writes to identity, status and results fall through: no storage
  // exists for them, so nothing a host writes can change them

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    read_next = UNMAPPED_READ_VALUE;
    case (reg_addr)
      ANALOG_CONTROL_ADDR: begin
        read_next = analog_control_reg;
      end
      PART_IDENTITY_ADDR: begin
        read_next = PART_ID;
      end
      DEVICE_STATUS_ADDR: begin
        read_next = status_view;
      end
      PROX_OFFSET_COMP_ADDR: begin
        read_next = prox_offset_comp_reg;
      end
      default: begin
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
          if (low_hit[ch]) begin
            read_next = results_in.word[ch][7:0];
          end else if (high_hit[ch]) begin
            read_next = high_shadow[ch];
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // ****************************************************************
  // led drive current
  // ****************************************************************
  always_comb begin
    if (led_current_reduce) begin
      led_current_next =
        LED_CURRENT_REDUCED[analog_control_reg.led_current_select];
    end else begin
      led_current_next =
        LED_CURRENT_FULL[analog_control_reg.led_current_select];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_current_x10 <= LED_CURRENT_FULL[0];
    end else begin
      led_current_x10 <= led_current_next;
    end
  end

  // ****************************************************************
  // proximity photodiode selection
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_photodiode_en <= 1'b0;
      second_photodiode_en <= 1'b0;
      diode_code_bad <= 1'b0;
    end else begin
      case (analog_control_reg.prox_photodiode_select)
        DIODE_FIRST: begin
          first_photodiode_en <= 1'b1;
          second_photodiode_en <= 1'b0;
          diode_code_bad <= 1'b0;
        end
        DIODE_SECOND: begin
          first_photodiode_en <= 1'b0;
          second_photodiode_en <= 1'b1;
          diode_code_bad <= 1'b0;
        end
        DIODE_RESERVED: begin
          // forbidden code: keep both diodes off and flag it
          first_photodiode_en <= 1'b0;
          second_photodiode_en <= 1'b0;
          diode_code_bad <= 1'b1;
        end
        default: begin
          first_photodiode_en <= 1'b0;
          second_photodiode_en <= 1'b0;
          diode_code_bad <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // gains
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prox_gain_factor <= PROX_GAIN_TABLE[0];
    end else begin
      prox_gain_factor <=
        PROX_GAIN_TABLE[analog_control_reg.prox_amp_gain];
    end
  end

  always_comb begin
    if (light_gain_reduce) begin
      // reduction only covers 1x and 8x; higher codes stay unscaled
      light_gain_next =
        LIGHT_GAIN_REDUCED[analog_control_reg.light_amp_gain];
    end else begin
      light_gain_next =
        LIGHT_GAIN_FULL[analog_control_reg.light_amp_gain];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      light_gain_x100 <= LIGHT_GAIN_FULL[0];
    end else begin
      light_gain_x100 <= light_gain_next;
    end
  end

  // ****************************************************************
  // proximity offset
  // ****************************************************************
  always_comb begin
    if (prox_offset_comp_reg[OFFSET_SIGN_BIT]) begin
      offset_signed_next = {1'b0, prox_offset_comp_reg[6:0]};
    end else begin
      offset_signed_next = 8'(-{1'b0, prox_offset_comp_reg[6:0]});
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prox_offset_positive <= 1'b0;
      prox_offset_magnitude <= 7'h00;
      prox_offset_signed <= 8'h00;
    end else begin
      prox_offset_positive <= prox_offset_comp_reg[OFFSET_SIGN_BIT];
      prox_offset_magnitude <= prox_offset_comp_reg[6:0];
      prox_offset_signed <= offset_signed_next;
    end
  end

endmodule : light_prox_sensor_regs

// ### tb/light_prox_regs_asserts.sv
// port checks for the light/proximity register bank
// assumes one clock domain; bound to the bank below
module light_prox_regs_asserts
  import light_prox_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
) (
  input wire logic sys_clk, // device clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid, // read answer
  input wire logic led_current_reduce, // drive reduce
  input wire logic light_gain_reduce, // gain reduce
  input wire status_in_t status_in, // status levels
  input wire results_t results_in, // live results
  input wire logic [10:0] led_current_x10, // led current
  input wire logic first_photodiode_en, // first diode
  input wire logic second_photodiode_en, // second diode
  input wire logic diode_code_bad, // reserved code
  input wire logic [3:0] prox_gain_factor, // prox gain
  input wire logic [13:0] light_gain_x100, // light gain
  input wire logic prox_offset_positive, // offset sign
  input wire logic [6:0] prox_offset_magnitude, // offset size
  input wire logic [7:0] prox_offset_signed // offset value
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dflt @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ********
  // access sequences
  // ********
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd && !reg_wr && reg_addr == a;
  endsequence
  sequence s_pair(logic [7:0] a);
    s_rd(a) ##1 s_rd(a + 8'h01);
  endsequence

  AST_READ_ANSWER:
    assert property ((reg_rd |=> reg_rvalid) and (!reg_rd |=> !reg_rvalid))
      else $error("read answer timing wrong");
  AST_CTRL_READBACK:
    assert property (s_wr(ANALOG_CONTROL_ADDR) ##1 !reg_wr
        ##1 s_rd(ANALOG_CONTROL_ADDR) |=> reg_rdata == $past(reg_wdata, 3))
      else $error("control readback wrong");
  AST_PART_ID:
    assert property (s_rd(PART_IDENTITY_ADDR) |=> reg_rdata == PART_ID)
      else $error("identity read wrong");
  AST_STATUS_MAP:
    assert property (s_rd(DEVICE_STATUS_ADDR) |=> reg_rdata ==
        {1'b0, $past(status_in[4:2]), 2'b00, $past(status_in[1:0])})
      else $error("status read wrong");
  AST_PROX_LOW_LIVE:
    assert property (s_rd(PROX_RESULT_LOW_ADDR) |=>
        reg_rdata == $past(results_in.word[2][7:0]))
      else $error("proximity low byte wrong");
  AST_CH0_SHADOW:
    assert property (s_pair(LIGHT_CHAN0_LOW_ADDR) |=>
        reg_rdata == $past(results_in.word[0][15:8], 2))
      else $error("light high byte not from shadow");
  AST_PROX_SHADOW:
    assert property (s_pair(PROX_RESULT_LOW_ADDR) |=>
        reg_rdata == $past(results_in.word[2][15:8], 2))
      else $error("proximity high byte not from shadow");
  AST_LED_DRIVE:
    assert property (s_wr(ANALOG_CONTROL_ADDR) |=> ##1 led_current_x10 ==
        ($past(led_current_reduce)
          ? LED_CURRENT_REDUCED[$past(reg_wdata[7:6], 2)]
          : LED_CURRENT_FULL[$past(reg_wdata[7:6], 2)]))
      else $error("led current wrong");
  AST_GAINS:
    assert property (s_wr(ANALOG_CONTROL_ADDR) |=> ##1
        prox_gain_factor == PROX_GAIN_TABLE[$past(reg_wdata[3:2], 2)] &&
        light_gain_x100 == ($past(light_gain_reduce)
          ? LIGHT_GAIN_REDUCED[$past(reg_wdata[1:0], 2)]
          : LIGHT_GAIN_FULL[$past(reg_wdata[1:0], 2)]))
      else $error("gain decode wrong");
  AST_DIODE:
    assert property (s_wr(ANALOG_CONTROL_ADDR) |=> ##1
        {diode_code_bad, second_photodiode_en, first_photodiode_en} ==
        {&$past(reg_wdata[5:4], 2), $past(reg_wdata[5:4], 2) == 2'b10,
         $past(reg_wdata[5:4], 2) == 2'b01})
      else $error("diode select wrong");
  AST_OFFSET:
    assert property (s_wr(PROX_OFFSET_COMP_ADDR) |=> ##1
        {prox_offset_positive, prox_offset_magnitude} == $past(reg_wdata, 2)
        && prox_offset_signed == ($past(reg_wdata[7], 2)
          ? {1'b0, $past(reg_wdata[6:0], 2)}
          : 8'h00 - {1'b0, $past(reg_wdata[6:0], 2)}))
      else $error("offset decode wrong");
  AST_OFFSET_RESET:
    assert property ($rose(rst_n) |-> prox_offset_signed == 8'h00 &&
        !prox_offset_positive && prox_offset_magnitude == 7'h00)
      else $error("offset not zero after reset");
endmodule : light_prox_regs_asserts

bind light_prox_sensor_regs light_prox_regs_asserts #(.PART_ID(PART_ID))
  chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .led_current_reduce(led_current_reduce),
  .light_gain_reduce(light_gain_reduce), .status_in(status_in),
  .results_in(results_in), .led_current_x10(led_current_x10),
  .first_photodiode_en(first_photodiode_en),
  .second_photodiode_en(second_photodiode_en),
  .diode_code_bad(diode_code_bad), .prox_gain_factor(prox_gain_factor),
  .light_gain_x100(light_gain_x100),
  .prox_offset_positive(prox_offset_positive),
  .prox_offset_magnitude(prox_offset_magnitude),
  .prox_offset_signed(prox_offset_signed)
);

// ### tb/light_prox_host.sv
// host model on the byte register port
// assumes the bank answers a read one cycle after its read edge
module light_prox_host
  import light_prox_pkg::*;
(
  input wire logic sys_clk, // device clock
  output logic [7:0] reg_addr, // register address
  output logic reg_wr, // write strobe
  output logic [7:0] reg_wdata, // write data
  output logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid // read answer
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    if (a == ANALOG_CONTROL_ADDR && d[5:4] == 2'b11) begin
      d[5:4] = 2'b00;
    end
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : write_reg

  // two set: low byte then high byte back to back
  task automatic read_seq(input logic [7:0] a, input logic two,
      output logic [15:0] d);
    d = 'x;
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= two;
    reg_addr <= a + 8'h01;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    d[7:0] = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    if (two) begin
      @(posedge sys_clk);
      d[15:8] = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    end
  endtask : read_seq
endmodule : light_prox_host

// ### tb/light_prox_sensor_regs_test.sv
// self-checking bench for the light/proximity register bank
// assumes the host model issues every register access
module light_prox_sensor_regs_test
  import light_prox_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_VALUE = 8'ha7; // arbitrary value
  localparam int LED_FULL [4] = '{1200, 600, 300, 150};
  localparam int LED_LOW [4] = '{150, 75, 38, 19};
  localparam int LG_FULL [4] = '{100, 800, 1600, 12000};
  localparam int LG_LOW [2] = '{16, 128};
  localparam logic [4:0] STAT_PAT [4] = '{5'h00, 5'h1f, 5'h15, 5'h0a};
  localparam logic [7:0] OFS_PAT [5] = '{8'h85, 8'h05, 8'hff, 8'h7f, 8'h80};
  logic sys_clk, rst_n, reg_wr, reg_rd, reg_rvalid, diode_code_bad;
  logic led_current_reduce, light_gain_reduce, prox_offset_positive;
  logic first_photodiode_en, second_photodiode_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, prox_offset_signed;
  logic [10:0] led_current_x10;
  logic [13:0] light_gain_x100;
  logic [6:0] prox_offset_magnitude;
  logic [3:0] prox_gain_factor;
  logic [15:0] rd;
  status_in_t status_in;
  results_t results_in;
  int checks, err_total;
  wire logic [7:0] ofs_raw = {prox_offset_positive, prox_offset_magnitude};

  light_prox_sensor_regs #(.PART_ID(ID_VALUE)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .led_current_reduce(led_current_reduce),
    .light_gain_reduce(light_gain_reduce), .status_in(status_in),
    .results_in(results_in), .led_current_x10(led_current_x10),
    .first_photodiode_en(first_photodiode_en),
    .second_photodiode_en(second_photodiode_en),
    .diode_code_bad(diode_code_bad), .prox_gain_factor(prox_gain_factor),
    .light_gain_x100(light_gain_x100),
    .prox_offset_positive(prox_offset_positive),
    .prox_offset_magnitude(prox_offset_magnitude),
    .prox_offset_signed(prox_offset_signed));
  light_prox_host host_u (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic t_reset;
    host_u.read_seq(PROX_OFFSET_COMP_ADDR, 1'b0, rd);
    chk("offset reg", 16'h0000, 16'(rd[7:0]));
    chk("offset out", 16'h0000, {prox_offset_signed, ofs_raw});
    host_u.read_seq(8'h20, 1'b0, rd);
    chk("unmapped", 16'h0000, 16'(rd[7:0]));
    $display("test reset done");
  endtask : t_reset

  task automatic t_control;
    logic [1:0] c, g;
    logic [7:0] v;
    logic [15:0] e;
    for (int i = 0; i < 8; i++) begin
      c = i[1:0];
      g = i[2] ? {1'b0, c[0]} : c;
      v = {c, (c == 2'b11) ? 2'b00 : c, c, g};
      @(posedge sys_clk);
      led_current_reduce <= i[2];
      light_gain_reduce <= i[2];
      host_u.write_reg(ANALOG_CONTROL_ADDR, v);
      host_u.read_seq(ANALOG_CONTROL_ADDR, 1'b0, rd);
      chk("control", 16'(v), 16'(rd[7:0]));
      e = 16'(i[2] ? LED_LOW[c] : LED_FULL[c]);
      chk("led", e, 16'(led_current_x10));
      chk("prox gain", 16'(1 << c), 16'(prox_gain_factor));
      e = 16'(i[2] ? LG_LOW[g[0]] : LG_FULL[g]);
      chk("light gain", e, 16'(light_gain_x100));
      e = 16'({1'b0, v[5:4]});
      chk("diodes", e, 16'({diode_code_bad, second_photodiode_en,
          first_photodiode_en}));
    end
    $display("test control done");
  endtask : t_control

  task automatic t_status;
    logic [4:0] p;
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      p = STAT_PAT[i];
      e = {1'b0, p[4:2], 2'b00, p[1:0]};
      @(posedge sys_clk);
      status_in <= p;
      host_u.write_reg(DEVICE_STATUS_ADDR, ~e);
      host_u.read_seq(DEVICE_STATUS_ADDR, 1'b0, rd);
      chk("status", 16'(e), 16'(rd[7:0]));
    end
    $display("test status done");
  endtask : t_status

  task automatic t_results;
    logic [7:0] a;
    logic [15:0] e;
    for (int ch = 0; ch < 3; ch++) begin
      a = 8'h14 + 8'(2 * ch);
      e = 16'h1234 + 16'(ch) * 16'h1111;
      @(posedge sys_clk);
      results_in.word[ch] <= e;
      host_u.write_reg(a, 8'hff);
      host_u.read_seq(a, 1'b1, rd);
      chk("pair", e, rd);
      host_u.read_seq(a, 1'b0, rd);
      @(posedge sys_clk);
      results_in.word[ch] <= ~e;
      host_u.write_reg(a + 8'h01, 8'h00);
      host_u.read_seq(a + 8'h01, 1'b0, rd);
      chk("shadow", 16'(e[15:8]), 16'(rd[7:0]));
    end
    host_u.write_reg(PART_IDENTITY_ADDR, ~ID_VALUE);
    host_u.read_seq(PART_IDENTITY_ADDR, 1'b0, rd);
    chk("identity", 16'(ID_VALUE), 16'(rd[7:0]));
    $display("test results done");
  endtask : t_results

  task automatic t_offset;
    logic [7:0] v, e;
    for (int i = 0; i < 5; i++) begin
      v = OFS_PAT[i];
      e = v[7] ? {1'b0, v[6:0]} : 8'h00 - {1'b0, v[6:0]};
      host_u.write_reg(PROX_OFFSET_COMP_ADDR, v);
      host_u.read_seq(PROX_OFFSET_COMP_ADDR, 1'b0, rd);
      chk("offset reg", 16'(v), 16'(rd[7:0]));
      chk("offset", {e, v}, {prox_offset_signed, ofs_raw});
    end
    // mid-run reset must clear a nonzero offset register
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    $display("test offset done");
  endtask : t_offset

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    rst_n = 1'b0;
    led_current_reduce = 1'b0;
    light_gain_reduce = 1'b0;
    status_in = '0;
    results_in = '0;
    checks = 0;
    err_total = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_control();
    t_status();
    t_results();
    t_offset();
    end_of_test();
  end

  // watchdog, about seventeen times the expected run
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
endmodule : light_prox_sensor_regs_test
